// [dlpi_cmd_map.sv]
// Process image command map: holds both halves of the cyclic image and turns
// simple-mode output image changes into lighting commands.
// Assumes the controller and the line engine are synchronous to clk.
//
// Behaviour
// - Simple mode default, full mode carries mailbox
// - Changed image bits are taken one per cycle, lowest first
// - Word 0 bits 0/1: broadcast on, off
// - One-button bit 2: toggle short, dim long
// - Two-button bit 2: on short, brighter long
// - Bit 3: toggle, or off/darker with two buttons
// - Bit 4 watchdog toggled; bits 5-15 ignored
// - Words 1-8: pairs for addresses 0-63
// - One-button first bit: toggle or dim
// - Two-button first bit: on or brighter
// - Second bit: toggle, or off/darker
// - Words 9-10: pairs for groups 0-15
// - Group pairs behave like address pairs
// - Full mode: all words are mailbox storage, none decoded
`default_nettype none
`include "dlpi_params.svh"

module dlpi_cmd_map #(
  parameter int LONG_CYC = `DLPI_CLK_HZ / 1000 * `DLPI_LONG_PRESS_MS,
  parameter int WDOG_CYC = `DLPI_CLK_HZ / 1000 * `DLPI_WDOG_MS
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Configuration levels
  input wire logic full_mode,
  input wire logic two_button,
  // Controller side of the image
  input wire dlpi_pkg::dlpi_acc_t ctl_acc,
  output logic [15:0] ctl_rdata,
  // Line engine side of the image
  input wire dlpi_pkg::dlpi_acc_t dev_acc,
  output logic [15:0] dev_rdata,
  // Commands and watchdog state
  output dlpi_pkg::dlpi_cmd_t cmd,
  output logic wdog_expired
);
  import dlpi_pkg::*;

  localparam int NB = `DLPI_IMG_WORDS * 16;

  ////////////////////////////////////////////////////////////////////////////
  // Bit roles and targets

  // Role of flat image bit b
  function automatic dlpi_role_t role_of(input logic [7:0] b);
    dlpi_role_t r;
    r = DLPI_R_NONE;
    if (b < 8'd16) begin
      unique case (b[3:0])
        4'(`DLPI_BIT_BC_ON): r = DLPI_R_ON;
        4'(`DLPI_BIT_BC_OFF): r = DLPI_R_OFF;
        4'(`DLPI_BIT_BC_FIRST): r = DLPI_R_FIRST;
        4'(`DLPI_BIT_BC_SECOND): r = DLPI_R_SECOND;
        4'(`DLPI_BIT_WDOG): r = DLPI_R_WDOG;
        default: r = DLPI_R_NONE; // Reserved and unused bits
      endcase
    end else if (b < 8'(16 * `DLPI_OFS_SCENE)) begin
      r = b[0] ? DLPI_R_SECOND : DLPI_R_FIRST;
    end else begin
      r = DLPI_R_SCENE;
    end
    return r;
  endfunction : role_of

  // Kind of target for flat image bit b
  function automatic dlpi_kind_t kind_of(input logic [7:0] b);
    dlpi_kind_t k;
    if (b < 8'd16) begin
      k = DLPI_K_BCAST;
    end else if (b < 8'(16 * `DLPI_OFS_GROUP_FIRST)) begin
      k = DLPI_K_SHORT;
    end else if (b < 8'(16 * `DLPI_OFS_SCENE)) begin
      k = DLPI_K_GROUP;
    end else begin
      k = DLPI_K_SCENE;
    end
    return k;
  endfunction : kind_of

  // Address of the target: pair index, group index or scene number
  function automatic logic [5:0] addr_of(input logic [7:0] b);
    logic [7:0] p;
    p = 8'd0;
    if (b >= 8'(16 * `DLPI_OFS_SCENE)) begin
      p = b - 8'(16 * `DLPI_OFS_SCENE);
    end else if (b >= 8'(16 * `DLPI_OFS_GROUP_FIRST)) begin
      p = (b - 8'(16 * `DLPI_OFS_GROUP_FIRST)) >> 1;
    end else if (b >= 8'd16) begin
      p = (b - 8'd16) >> 1;
    end
    return p[5:0];
  endfunction : addr_of

  // A bit is a press button when its length matters
  function automatic logic is_press(input logic [7:0] b, input logic two);
    dlpi_role_t r;
    r = role_of(b);
    return (r == DLPI_R_FIRST) || (r == DLPI_R_SECOND && two);
  endfunction : is_press

  ////////////////////////////////////////////////////////////////////////////
  // Image storage and read ports

  dlpi_word_t out_img_q [`DLPI_IMG_WORDS];
  dlpi_word_t out_img_d [`DLPI_IMG_WORDS];
  dlpi_word_t in_img_q [`DLPI_IMG_WORDS];
  dlpi_word_t in_img_d [`DLPI_IMG_WORDS];
  logic [15:0] ctl_rdata_q, ctl_rdata_d;
  logic [15:0] dev_rdata_q, dev_rdata_d;
  logic [NB-1:0] flat;

  // Flatten the output image for change detection
  genvar gw;
  generate
    for (gw = 0; gw < `DLPI_IMG_WORDS; gw++) begin : g_flat
      assign flat[gw*16 +: 16] = out_img_q[gw];
    end
  endgenerate

  // Writes land in their half; in full mode both halves are mailbox words
  always_comb begin
    for (int i = 0; i < `DLPI_IMG_WORDS; i++) begin
      out_img_d[i] = out_img_q[i];
      in_img_d[i] = in_img_q[i];
    end
    if (ctl_acc.wr && ctl_acc.addr < 4'(`DLPI_IMG_WORDS)) begin
      out_img_d[ctl_acc.addr] = ctl_acc.wdata;
    end
    if (dev_acc.wr && dev_acc.addr < 4'(`DLPI_IMG_WORDS)) begin
      in_img_d[dev_acc.addr] = dev_acc.wdata;
    end
    ctl_rdata_d = 16'h0000;
    dev_rdata_d = 16'h0000;
    if (ctl_acc.addr < 4'(`DLPI_IMG_WORDS)) begin
      ctl_rdata_d = in_img_q[ctl_acc.addr];
    end
    if (dev_acc.addr < 4'(`DLPI_IMG_WORDS)) begin
      dev_rdata_d = out_img_q[dev_acc.addr];
    end
  end

  // Image registers
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < `DLPI_IMG_WORDS; i++) begin
        out_img_q[i] <= `DLPI_WORD_RST;
        in_img_q[i] <= `DLPI_WORD_RST;
      end
      ctl_rdata_q <= 16'h0000;
      dev_rdata_q <= 16'h0000;
    end else begin
      for (int i = 0; i < `DLPI_IMG_WORDS; i++) begin
        out_img_q[i] <= out_img_d[i];
        in_img_q[i] <= in_img_d[i];
      end
      ctl_rdata_q <= ctl_rdata_d;
      dev_rdata_q <= dev_rdata_d;
    end
  end

  assign ctl_rdata = ctl_rdata_q;
  assign dev_rdata = dev_rdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // Change scanner, press tracker and watchdog

  logic [NB-1:0] prev_q, prev_d;
  logic busy_q, busy_d;
  logic [7:0] trk_idx_q, trk_idx_d;
  logic [23:0] trk_cnt_q, trk_cnt_d;
  logic trk_long_q, trk_long_d;
  logic dim_up_q, dim_up_d;
  logic [23:0] wd_cnt_q, wd_cnt_d;
  logic wd_armed_q, wd_armed_d;
  logic wd_exp_q, wd_exp_d;
  dlpi_cmd_t cmd_q, cmd_d;
  logic found;
  logic [7:0] pick;
  logic rise;
  dlpi_role_t prole;
  dlpi_role_t trole;

  // Lowest changed bit; other presses wait while one is tracked
  always_comb begin
    found = 1'b0;
    pick = 8'd0;
    for (int b = NB - 1; b >= 0; b--) begin
      if ((flat[b] ^ prev_q[b]) &&
          !(busy_q && is_press(8'(b), two_button) && 8'(b) != trk_idx_q)) begin
        found = 1'b1;
        pick = 8'(b);
      end
    end
  end

  assign rise = flat[pick];
  assign prole = role_of(pick);
  assign trole = role_of(trk_idx_q);

  // Next state of the command engine
  always_comb begin
    prev_d = prev_q;
    busy_d = busy_q;
    trk_idx_d = trk_idx_q;
    trk_cnt_d = trk_cnt_q;
    trk_long_d = trk_long_q;
    dim_up_d = dim_up_q;
    wd_cnt_d = wd_cnt_q;
    wd_armed_d = wd_armed_q;
    wd_exp_d = wd_exp_q;
    cmd_d = '{valid: 1'b0, kind: DLPI_K_BCAST, addr: 6'd0, op: DLPI_OP_ON};
    if (wd_armed_q && !wd_exp_q) begin
      if (wd_cnt_q == 24'(WDOG_CYC - 1)) begin
        wd_exp_d = 1'b1; // Controller stopped toggling
      end else begin
        wd_cnt_d = wd_cnt_q + 24'd1;
      end
    end
    if (busy_q && !trk_long_q) begin
      trk_cnt_d = trk_cnt_q + 24'd1;
    end
    if (full_mode) begin
      // Mailbox content never turns into commands
      prev_d = flat;
      busy_d = 1'b0;
      trk_long_d = 1'b0;
    end else if (busy_q && !trk_long_q && trk_cnt_q == 24'(LONG_CYC - 1)) begin
      // Held long enough: start dimming
      trk_long_d = 1'b1;
      cmd_d = '{valid: 1'b1, kind: kind_of(trk_idx_q), addr: addr_of(trk_idx_q),
                op: DLPI_OP_DIM_UP};
      if (trole == DLPI_R_SECOND) begin
        cmd_d.op = DLPI_OP_DIM_DOWN;
      end else if (!two_button && !dim_up_q) begin
        cmd_d.op = DLPI_OP_DIM_DOWN;
      end
    end else if (found) begin
      prev_d[pick] = rise;
      cmd_d.kind = kind_of(pick);
      cmd_d.addr = addr_of(pick);
      unique case (prole)
        DLPI_R_ON: begin
          cmd_d.valid = rise;
          cmd_d.op = DLPI_OP_ON;
        end
        DLPI_R_OFF: begin
          cmd_d.valid = rise;
          cmd_d.op = DLPI_OP_OFF;
        end
        DLPI_R_WDOG: begin
          wd_armed_d = 1'b1; // Either edge counts as a toggle
          wd_cnt_d = 24'd0;
          wd_exp_d = wd_exp_d && !wd_exp_q; // Expiry in the same cycle wins
        end
        DLPI_R_SCENE: begin
          cmd_d.valid = rise;
          cmd_d.op = DLPI_OP_RECALL;
        end
        DLPI_R_FIRST, DLPI_R_SECOND: begin
          if (prole == DLPI_R_SECOND && !two_button) begin
            cmd_d.valid = rise; // Plain toggle
            cmd_d.op = DLPI_OP_TOGGLE;
          end else if (rise) begin
            busy_d = 1'b1; // Start timing the press
            trk_idx_d = pick;
            trk_cnt_d = 24'd0;
            trk_long_d = 1'b0;
          end else if (busy_q && pick == trk_idx_q) begin
            busy_d = 1'b0;
            trk_long_d = 1'b0;
            cmd_d.valid = 1'b1;
            if (trk_long_q) begin
              cmd_d.op = DLPI_OP_DIM_STOP;
              if (!two_button) begin
                dim_up_d = !dim_up_q; // Next long press dims the other way
              end
            end else if (!two_button) begin
              cmd_d.op = DLPI_OP_TOGGLE;
            end else if (prole == DLPI_R_FIRST) begin
              cmd_d.op = DLPI_OP_ON;
            end else begin
              cmd_d.op = DLPI_OP_OFF;
            end
          end
        end
        DLPI_R_NONE: begin
          cmd_d.valid = 1'b0; // Reserved bits
        end
      endcase
    end
  end

  // Command engine registers
  always_ff @(posedge clk) begin
    if (rst) begin
      prev_q <= '0;
      busy_q <= 1'b0;
      trk_idx_q <= 8'd0;
      trk_cnt_q <= 24'd0;
      trk_long_q <= 1'b0;
      dim_up_q <= 1'b1;
      wd_cnt_q <= 24'd0;
      wd_armed_q <= 1'b0;
      wd_exp_q <= 1'b0;
      cmd_q <= '{valid: 1'b0, kind: DLPI_K_BCAST, addr: 6'd0, op: DLPI_OP_ON};
    end else begin
      prev_q <= prev_d;
      busy_q <= busy_d;
      trk_idx_q <= trk_idx_d;
      trk_cnt_q <= trk_cnt_d;
      trk_long_q <= trk_long_d;
      dim_up_q <= dim_up_d;
      wd_cnt_q <= wd_cnt_d;
      wd_armed_q <= wd_armed_d;
      wd_exp_q <= wd_exp_d;
      cmd_q <= cmd_d;
    end
  end

  assign cmd = cmd_q;
  assign wdog_expired = wd_exp_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  AST_FULL_QUIET: assert property (full_mode |=> !cmd_q.valid)
    else $error("command issued in full mode");
  AST_BC_ON: assert property (cmd_q.valid && cmd_q.kind == DLPI_K_BCAST &&
      cmd_q.op == DLPI_OP_ON |-> $past(out_img_q[0][0]) || $past(two_button))
    else $error("broadcast on without its bit");
  AST_BC_OFF: assert property (cmd_q.valid && cmd_q.kind == DLPI_K_BCAST &&
      cmd_q.op == DLPI_OP_OFF |-> $past(out_img_q[0][1]) || $past(two_button))
    else $error("broadcast off without its bit");
  AST_DIM_STOP: assert property (cmd_q.valid && cmd_q.op == DLPI_OP_DIM_STOP
      |-> $past(trk_long_q) && !busy_q)
    else $error("dim stop without long press");
  AST_LONG_TIME: assert property ($rose(trk_long_q) && !$past(rst)
      |-> $past(trk_cnt_q) == 24'(LONG_CYC - 1) && cmd_q.valid)
    else $error("long press at wrong time");
  AST_WDOG: assert property ($rose(wd_exp_q)
      |-> $past(wd_armed_q) && $past(wd_cnt_q) == 24'(WDOG_CYC - 1))
    else $error("watchdog expired early");
  AST_GROUP_RANGE: assert property (cmd_q.valid && cmd_q.kind == DLPI_K_GROUP
      |-> cmd_q.addr < 6'd16)
    else $error("group address out of range");
  AST_SCENE: assert property (cmd_q.valid && cmd_q.op == DLPI_OP_RECALL
      |-> cmd_q.kind == DLPI_K_SCENE &&
      |($past(out_img_q[11]) & (16'h0001 << cmd_q.addr[3:0])))
    else $error("scene recall without its bit");
  AST_TWO_DOWN: assert property (cmd_q.valid && cmd_q.op == DLPI_OP_DIM_DOWN &&
      $past(two_button) |-> $past(trole) == DLPI_R_SECOND)
    else $error("darker from wrong bit");
  AST_TWO_ON: assert property (cmd_q.valid && cmd_q.op == DLPI_OP_ON &&
      cmd_q.kind != DLPI_K_BCAST |-> $past(two_button))
    else $error("switch on outside two-button use");
  AST_ONE_TOGGLE: assert property (cmd_q.valid && cmd_q.op == DLPI_OP_TOGGLE
      |-> !$past(two_button))
    else $error("toggle in two-button use");
  AST_UP_FIRST: assert property (cmd_q.valid && cmd_q.op == DLPI_OP_DIM_UP
      |-> $past(trole) == DLPI_R_FIRST)
    else $error("brighter from wrong bit");

endmodule : dlpi_cmd_map

`default_nettype wire

// [dlpi_cmd_map_unused_guard.sv]
// Empty unit: holds no logic of its own.
// Assumes nothing of its surroundings.
`default_nettype none
`default_nettype wire

// [dlpi_ctl_model.sv]
// Controller model: writes the output image and reads the input image.
// Assumes dlpi_pkg is compiled first and clk is the block clock.
`default_nettype none

module dlpi_ctl_model (
  // Clock
  input wire logic clk,
  // Image access
  output var dlpi_pkg::dlpi_acc_t ctl_acc,
  input wire logic [15:0] ctl_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  import dlpi_pkg::*;

  // Copy of what the controller wrote
  dlpi_word_t img [12];

  // Idle bus at time zero
  initial begin
    ctl_acc = '0;
    foreach (img[i]) img[i] = 16'h0000;
  end

  ////////////////////////////////////////////////////////////////////////////
  // One-cycle strobe; data inverted once released
  task automatic write_word(input logic [3:0] a, input dlpi_word_t d);
    @(posedge clk);
    #10;
    ctl_acc.wr = 1'b1;
    ctl_acc.addr = a;
    ctl_acc.wdata = d;
    if (a < 4'hc) img[a] = d;
    @(posedge clk);
    #10;
    ctl_acc.wr = 1'b0;
    ctl_acc.wdata = ~d;
  endtask : write_word

  // Change one bit, keep the rest of the word
  task automatic set_bit(input logic [3:0] a, input logic [3:0] b, input logic v);
    dlpi_word_t d;
    d = img[a];
    d[b] = v;
    write_word(a, d);
  endtask : set_bit

  // Watchdog kept alive by flipping its bit
  task automatic toggle_wdog();
    set_bit(4'h0, 4'h4, ~img[0][4]);
  endtask : toggle_wdog

  // Address taken at one edge, data seen after the next
  task automatic read_word(input logic [3:0] a, output dlpi_word_t d);
    @(posedge clk);
    #10;
    ctl_acc.addr = a;
    @(posedge clk);
    #10;
    d = ctl_rdata;
  endtask : read_word
endmodule : dlpi_ctl_model

`default_nettype wire

// [dlpi_params.svh]
// Constants for the lighting-bus process image command map.
// Assumes a single 10 MHz clock; included by dlpi_pkg and dlpi_cmd_map.
`ifndef DLPI_PARAMS_SVH
`define DLPI_PARAMS_SVH

// Clock rate in Hz
`define DLPI_CLK_HZ 10000000
// Image size in 16-bit words and bytes
`define DLPI_IMG_WORDS 12
`define DLPI_IMG_BYTES 24
// Word offsets of the image
`define DLPI_OFS_CTRL 4'h0
`define DLPI_OFS_PAIR_FIRST 4'h1
`define DLPI_OFS_PAIR_LAST 4'h8
`define DLPI_OFS_GROUP_FIRST 4'h9
`define DLPI_OFS_GROUP_LAST 4'ha
`define DLPI_OFS_SCENE 4'hb
// Bit positions in word 0
`define DLPI_BIT_BC_ON 0
`define DLPI_BIT_BC_OFF 1
`define DLPI_BIT_BC_FIRST 2
`define DLPI_BIT_BC_SECOND 3
`define DLPI_BIT_WDOG 4
// Image reset value
`define DLPI_WORD_RST 16'h0000
// Press and watchdog times in milliseconds
`define DLPI_LONG_PRESS_MS 500
`define DLPI_WDOG_MS 1000

`endif

// [dlpi_pkg.sv]
// Types shared by the process image command map.
// Assumes dlpi_params.svh is on the include path.
`default_nettype none
`include "dlpi_params.svh"

package dlpi_pkg;
  // Image word
  typedef logic [15:0] dlpi_word_t;
  // Addressed target of a lighting command
  typedef enum logic [1:0] {
    DLPI_K_BCAST = 2'h0,
    DLPI_K_SHORT = 2'h1,
    DLPI_K_GROUP = 2'h2,
    DLPI_K_SCENE = 2'h3
  } dlpi_kind_t;
  // Lighting operation
  typedef enum logic [2:0] {
    DLPI_OP_ON = 3'h0,
    DLPI_OP_OFF = 3'h1,
    DLPI_OP_TOGGLE = 3'h2,
    DLPI_OP_DIM_UP = 3'h3,
    DLPI_OP_DIM_DOWN = 3'h4,
    DLPI_OP_DIM_STOP = 3'h5,
    DLPI_OP_RECALL = 3'h6
  } dlpi_op_t;
  // Role of one image bit in the simple mode
  typedef enum logic [2:0] {
    DLPI_R_NONE = 3'h0,
    DLPI_R_ON = 3'h1,
    DLPI_R_OFF = 3'h2,
    DLPI_R_FIRST = 3'h3,
    DLPI_R_SECOND = 3'h4,
    DLPI_R_WDOG = 3'h5,
    DLPI_R_SCENE = 3'h6
  } dlpi_role_t;
  // Command to the line engine
  typedef struct packed {
    logic valid;
    dlpi_kind_t kind;
    logic [5:0] addr;
    dlpi_op_t op;
  } dlpi_cmd_t;
  // Image access from one side
  typedef struct packed {
    logic wr;
    logic [3:0] addr;
    dlpi_word_t wdata;
  } dlpi_acc_t;
endpackage : dlpi_pkg

`default_nettype wire

// [tb_top.sv]
// Self-checking bench for the process image command map.
// Assumes dlpi_pkg, dlpi_cmd_map and dlpi_ctl_model are compiled first.
`default_nettype none

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import dlpi_pkg::*;

  localparam int LONG_T = 20;
  localparam int WDOG_T = 50;
  localparam int TMO = 20000;
  logic clk;
  logic rst;
  logic full_mode;
  logic two_button;
  dlpi_acc_t ctl_acc;
  dlpi_acc_t dev_acc;
  logic [15:0] ctl_rdata;
  logic [15:0] dev_rdata;
  dlpi_cmd_t cmd;
  logic wdog_expired;
  int num_errors = 0;
  int checks = 0;
  int cycles = 0;
  dlpi_cmd_t exp_q[$];

  dlpi_cmd_map #(.LONG_CYC(LONG_T), .WDOG_CYC(WDOG_T)) uut (
    .clk(clk), .rst(rst), .full_mode(full_mode), .two_button(two_button),
    .ctl_acc(ctl_acc), .ctl_rdata(ctl_rdata), .dev_acc(dev_acc), .dev_rdata(dev_rdata),
    .cmd(cmd), .wdog_expired(wdog_expired)
  );

  dlpi_ctl_model u_ctl (.clk(clk), .ctl_acc(ctl_acc), .ctl_rdata(ctl_rdata));

  // 100 ns clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic give_verdict();
    $display("TB: checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : give_verdict

  // Note one expected command
  task automatic push(input dlpi_kind_t k, input int a, input dlpi_op_t op);
    dlpi_cmd_t c;
    c.valid = 1'b1;
    c.kind = k;
    c.addr = 6'(a);
    c.op = op;
    exp_q.push_back(c);
  endtask : push

  // Line engine access; returns output image word for the address
  task automatic dev_op(input logic w, input logic [3:0] a, input dlpi_word_t d,
                        output dlpi_word_t q);
    @(posedge clk);
    #10;
    dev_acc.wr = w;
    dev_acc.addr = a;
    dev_acc.wdata = d;
    @(posedge clk);
    #10;
    dev_acc.wr = 1'b0;
    dev_acc.wdata = ~d;
    q = dev_rdata;
  endtask : dev_op

  // Hold one bit for a number of cycles, then release
  task automatic press(input int w, input int b, input int hold);
    u_ctl.set_bit(4'(w), 4'(b), 1'b1);
    repeat (hold) @(posedge clk);
    u_ctl.set_bit(4'(w), 4'(b), 1'b0);
    repeat (4) @(posedge clk);
    #10;
  endtask : press

  // Nothing may be left outstanding
  task automatic drain();
    repeat (4) @(posedge clk);
    #10;
    check("pending cmds", 16'(exp_q.size()), 16'h0000);
    exp_q.delete();
  endtask : drain

  // Both operating styles of one bit pair
  task automatic run_pair(input dlpi_kind_t k, input int a, input int w, input int b0);
    two_button = 1'b0;
    push(k, a, DLPI_OP_TOGGLE);
    press(w, b0 + 1, 3);
    push(k, a, DLPI_OP_TOGGLE);
    press(w, b0, 3);
    for (int i = 0; i < 2; i++) begin
      push(k, a, (i == 0) ? DLPI_OP_DIM_UP : DLPI_OP_DIM_DOWN);
      push(k, a, DLPI_OP_DIM_STOP);
      press(w, b0, LONG_T + 5);
    end
    two_button = 1'b1;
    push(k, a, DLPI_OP_ON);
    press(w, b0, 3);
    push(k, a, DLPI_OP_DIM_UP);
    push(k, a, DLPI_OP_DIM_STOP);
    press(w, b0, LONG_T + 5);
    push(k, a, DLPI_OP_OFF);
    press(w, b0 + 1, 3);
    push(k, a, DLPI_OP_DIM_DOWN);
    push(k, a, DLPI_OP_DIM_STOP);
    press(w, b0 + 1, LONG_T + 5);
    drain();
  endtask : run_pair

  ////////////////////////////////////////////////////////////////////////////
  // Command monitor and hang limit, sampled mid-cycle
  always @(negedge clk) begin
    cycles++;
    if (!rst && cmd.valid === 1'b1) begin
      if (exp_q.size() == 0) check("unexpected cmd", 16'(cmd), 16'h0000);
      else check("cmd", 16'(cmd), 16'(exp_q.pop_front()));
    end
    if (cycles == TMO) begin
      num_errors++;
      give_verdict();
    end
  end

  // Main sequence
  initial begin
    int a;
    int tgt [5];
    dlpi_word_t d;
    rst = 1'b1;
    full_mode = 1'b0;
    two_button = 1'b0;
    dev_acc = '0;
    void'($urandom(45));
    repeat (10) @(posedge clk);
    #10;
    rst = 1'b0;
    check("wdog after reset", 16'(wdog_expired), 16'h0000);
    dev_op(1'b0, 4'h0, 16'h0000, d);
    check("image after reset", d, 16'h0000);
    // Broadcast on and off; falls and reserved bits silent
    push(DLPI_K_BCAST, 0, DLPI_OP_ON);
    u_ctl.write_word(4'h0, 16'h0001);
    push(DLPI_K_BCAST, 0, DLPI_OP_OFF);
    u_ctl.write_word(4'h0, 16'h0003);
    u_ctl.write_word(4'h0, 16'hffe0);
    u_ctl.write_word(4'h0, 16'h0000);
    drain();
    // Broadcast, boundary and random short addresses, groups
    a = $urandom_range(62, 1);
    tgt = '{0, 63, a, 15, $urandom_range(14, 0)};
    run_pair(DLPI_K_BCAST, 0, 0, 2);
    for (int i = 0; i < 3; i++) begin
      run_pair(DLPI_K_SHORT, tgt[i], 1 + tgt[i] / 8, 2 * (tgt[i] % 8));
    end
    for (int i = 3; i < 5; i++) begin
      run_pair(DLPI_K_GROUP, tgt[i], 9 + tgt[i] / 8, 2 * (tgt[i] % 8));
    end
    // Every scene
    for (int n = 0; n < 16; n++) begin
      push(DLPI_K_SCENE, n, DLPI_OP_RECALL);
      press(11, n, 2);
    end
    drain();
    // Full mode: plain storage both ways, no commands
    full_mode = 1'b1;
    for (int i = 0; i < 12; i++) begin
      d = 16'($urandom());
      if (i == 0) d[4] = 1'b0;
      u_ctl.write_word(4'(i), d);
      dev_op(1'b1, 4'(i), ~d, d);
    end
    u_ctl.write_word(4'hc, 16'h5a5a);
    for (int i = 0; i < 13; i++) begin
      dev_op(1'b0, 4'(i), 16'h0000, d);
      check("output image", d, (i < 12) ? u_ctl.img[i] : 16'h0000);
      u_ctl.read_word(4'(i), d);
      check("input image", d, (i < 12) ? ~u_ctl.img[i] : 16'h0000);
    end
    for (int i = 0; i < 12; i++) u_ctl.write_word(4'(i), 16'h0000);
    full_mode = 1'b0;
    drain();
    // Watchdog restart and expiry
    u_ctl.toggle_wdog();
    repeat (WDOG_T - 10) @(posedge clk);
    #10;
    check("wdog early", 16'(wdog_expired), 16'h0000);
    u_ctl.toggle_wdog();
    repeat (WDOG_T - 10) @(posedge clk);
    #10;
    check("wdog restarted", 16'(wdog_expired), 16'h0000);
    repeat (20) @(posedge clk);
    #10;
    check("wdog expired", 16'(wdog_expired), 16'h0001);
    drain();
    give_verdict();
  end
endmodule : tb_top

`default_nettype wire
